// file: src/cp_ctrl_pkg.sv
package cp_ctrl_pkg;
  // Coprocessor register numbers and minor field codes.
  localparam logic [3:0]  CRN_CACHE   = 4'h7;
  localparam logic [3:0]  CRN_TLB     = 4'h8;
  localparam logic [3:0]  CRN_LOCK    = 4'h9;
  localparam logic [3:0]  CRM_C0      = 4'h0;
  localparam logic [3:0]  CRM_C1      = 4'h1;
  localparam logic [3:0]  CRM_C5      = 4'h5;
  localparam logic [3:0]  CRM_C6      = 4'h6;
  localparam logic [3:0]  CRM_C7      = 4'h7;
  localparam logic [3:0]  CRM_C10     = 4'hA;
  localparam logic [3:0]  CRM_C14     = 4'hE;
  localparam logic [2:0]  OP2_0       = 3'h0;
  localparam logic [2:0]  OP2_MVA     = 3'h1;
  localparam logic [2:0]  OP2_SETWAY  = 3'h2;
  localparam logic [2:0]  OP2_TEST    = 3'h3;
  localparam logic [2:0]  OP2_WB      = 3'h4;
  // Data cache geometry: four ways, eight-word lines, 128 sets.
  localparam int          WAYS_LOG2   = 2;
  localparam int          SETS_LOG2   = 7;
  localparam int          LINE_LSB    = 5;
  localparam int          LOCK_W      = 4;
  localparam logic [1:0]  FALLBACK_WAY = 2'h3;
  localparam logic [3:0]  LOCK_RESET  = 4'h0;
  localparam logic [11:0] SBO_FIELD   = 12'hFFF;
  localparam int          CLEAN_BIT   = 30;
  localparam int          FLAGS_LSB   = 28;
  localparam int          TLB_MVA_LSB = 10;
  // Register map of the command port on the core side.
  localparam logic [11:0] OFF_CMD     = 12'h000;
  localparam logic [11:0] OFF_WDATA   = 12'h004;
  localparam logic [11:0] OFF_RDATA   = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00C;
  localparam int          CMD_CRN_LSB = 0;
  localparam int          CMD_CRM_LSB = 4;
  localparam int          CMD_OP2_LSB = 8;
  localparam int          CMD_WR_BIT  = 11;
  localparam int          CMD_PC_BIT  = 12;
  localparam int          STA_BUSY_BIT = 0;
  localparam int          STA_REF_BIT = 1;
  localparam int          STA_FLAGS_LSB = 4;

  typedef enum logic [2:0] {
    COP_NONE, COP_INV_SW, COP_CLEAN_MVA, COP_CLEAN_SW,
    COP_CINV_MVA, COP_CINV_SW, COP_TEST_CLEAN, COP_INV_ALL
  } cache_op_e;
endpackage : cp_ctrl_pkg

// file: src/cp_link_if.sv
`timescale 1ns/1ns
interface cp_link_if (
  input wire logic pclk,    // Core clock.
  input wire logic presetn  // Core reset, active low.
);
  logic        req;         // Transfer request, held until ack.
  logic        wr;          // 1 = coprocessor write, 0 = read.
  logic [3:0]  crn;         // Primary register number.
  logic [3:0]  coproc_minor_reg_field;         // Minor register field.
  logic [2:0]  op2;         // Second opcode.
  logic        dest_pc;     // Read names r15 as destination.
  logic [31:0] wdata;       // Write operand.
  logic        ack;         // One-cycle completion pulse.
  logic [31:0] rdata;       // Read result, valid with ack.
  logic        flags_load;  // Load rdata[31:28] into flags, with ack.

  modport core   (input pclk, presetn, ack, rdata, flags_load,
                  output req, wr, crn, coproc_minor_reg_field, op2, dest_pc, wdata);
  modport coproc (input pclk, presetn, req, wr, crn, coproc_minor_reg_field, op2, dest_pc, wdata,
                  output ack, rdata, flags_load);
endinterface : cp_link_if

// file: src/cache_tlb_maint_lockdown_ctrl.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module cache_tlb_maint_lockdown_ctrl #(
  parameter int SETS_LOG2 = cp_ctrl_pkg::SETS_LOG2,  // Log2 of data cache sets.
  parameter int WAYS_LOG2 = cp_ctrl_pkg::WAYS_LOG2   // Log2 of data cache ways.
) (
  cp_link_if.coproc                     lnk,              // Transfers from the core.
  output logic                          cache_req,        // Data cache operation request, level.
  output cp_ctrl_pkg::cache_op_e        cache_op,         // Operation kind.
  output logic [SETS_LOG2-1:0]          cache_set,        // Set index for set/way operations.
  output logic [WAYS_LOG2-1:0]          cache_way,        // Way for set/way operations.
  output logic [31:0]                   cache_mva,        // Line address for address operations.
  input  wire logic                     cache_done,       // Operation finished, one cycle.
  input  wire logic                     cache_dirty_left, // Dirty lines remain, valid with done.
  output logic                          tlb_inv_all,      // Invalidate unpreserved TLB entries, pulse.
  output logic                          tlb_inv_one,      // Invalidate matching TLB entry, pulse.
  output logic [31-cp_ctrl_pkg::TLB_MVA_LSB:0] tlb_mva,   // Address for single-entry invalidate.
  output logic                          wb_drain,         // Write buffer drain request, level.
  input  wire logic                     wb_empty,         // Write buffer empty.
  output logic                          low_power,        // Core in low-power wait.
  input  wire logic                     irq_pin,          // Interrupt request, asynchronous.
  input  wire logic                     dbg_pin,          // Debug request, asynchronous.
  input  wire logic [1:0]               d_repl_way,       // Data replacement candidate.
  input  wire logic [1:0]               i_repl_way,       // Instruction replacement candidate.
  output logic [1:0]                    d_fill_way,       // Data linefill target way.
  output logic [1:0]                    i_fill_way        // Instruction linefill target way.
);
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_CACHE, ST_INV, ST_WAIT_WB, ST_SLEEP} dev_state_e;

  typedef struct packed {
    dev_state_e                          st;
    logic                                ack;
    logic [31:0]                         rdata;
    logic                                flags_load;
    logic                                dest_pc;
    logic                                tci;
    logic                                wfi;
    logic [cp_ctrl_pkg::LOCK_W-1:0]      dlock;
    logic [cp_ctrl_pkg::LOCK_W-1:0]      ilock;
    logic [1:0]                          dfill;
    logic [1:0]                          ifill;
    logic                                cache_req;
    cp_ctrl_pkg::cache_op_e              cache_op;
    logic [SETS_LOG2-1:0]                cset;
    logic [WAYS_LOG2-1:0]                cway;
    logic [31:0]                         cmva;
    logic                                tlb_all;
    logic                                tlb_one;
    logic [31-cp_ctrl_pkg::TLB_MVA_LSB:0] tlb_mva;
    logic                                wb_drain;
    logic                                low_power;
    logic [1:0]                          irq_s;
    logic [1:0]                          dbg_s;
  } dev_s;

  dev_s st_ff;
  dev_s nxt_st;

  // Picks the first open way from the candidate upward; with every way
  // locked the fill falls back to way 3 rather than stalling.
  function automatic logic [1:0] pick_way(input logic [cp_ctrl_pkg::LOCK_W-1:0] lock,
                                          input logic [1:0] cand);
    logic [1:0] w;
    logic       found;
    pick_way = cp_ctrl_pkg::FALLBACK_WAY;
    found = 1'b0;
    for (int k = 0; k < cp_ctrl_pkg::LOCK_W; k++) begin
      w = cand + 2'(k);
      if (!found && !lock[w]) begin
        pick_way = w;
        found = 1'b1;
      end
    end
  endfunction : pick_way

  // Maps a cache register write to its line operation.
  function automatic cp_ctrl_pkg::cache_op_e dec_line_op(input logic [3:0] coproc_minor_reg_field, input logic [2:0] op2);
    dec_line_op = cp_ctrl_pkg::COP_NONE;
    case (coproc_minor_reg_field)
      cp_ctrl_pkg::CRM_C6: begin
        if (op2 == cp_ctrl_pkg::OP2_SETWAY) dec_line_op = cp_ctrl_pkg::COP_INV_SW;
      end
      cp_ctrl_pkg::CRM_C10: begin
        if (op2 == cp_ctrl_pkg::OP2_MVA) dec_line_op = cp_ctrl_pkg::COP_CLEAN_MVA;
        if (op2 == cp_ctrl_pkg::OP2_SETWAY) dec_line_op = cp_ctrl_pkg::COP_CLEAN_SW;
      end
      cp_ctrl_pkg::CRM_C14: begin
        if (op2 == cp_ctrl_pkg::OP2_MVA) dec_line_op = cp_ctrl_pkg::COP_CINV_MVA;
        if (op2 == cp_ctrl_pkg::OP2_SETWAY) dec_line_op = cp_ctrl_pkg::COP_CINV_SW;
      end
      default: dec_line_op = cp_ctrl_pkg::COP_NONE;
    endcase
  endfunction : dec_line_op

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.flags_load = 1'b0;
    nxt_st.tlb_all = 1'b0;
    nxt_st.tlb_one = 1'b0;
    nxt_st.irq_s = {st_ff.irq_s[0], irq_pin};
    nxt_st.dbg_s = {st_ff.dbg_s[0], dbg_pin};
    nxt_st.dfill = pick_way(st_ff.dlock, d_repl_way);
    nxt_st.ifill = pick_way(st_ff.ilock, i_repl_way);
    case (st_ff.st)
      ST_IDLE: begin
        // The guard on ack stops the request still held in the ack cycle from starting twice.
        if (lnk.req && !st_ff.ack) begin
          nxt_st.ack = 1'b1;
          nxt_st.rdata = '0;
          nxt_st.dest_pc = lnk.dest_pc;
          nxt_st.tci = 1'b0;
          nxt_st.wfi = 1'b0;
          // Address and set/way fields are taken from one decode of the operand.
          nxt_st.cmva = {lnk.wdata[31:cp_ctrl_pkg::LINE_LSB], cp_ctrl_pkg::LINE_LSB'(0)};
          nxt_st.cset = lnk.wdata[cp_ctrl_pkg::LINE_LSB +: SETS_LOG2];
          nxt_st.cway = lnk.wdata[31 -: WAYS_LOG2];
          case (lnk.crn)
            cp_ctrl_pkg::CRN_CACHE: begin
              if (lnk.wr) begin
                if (dec_line_op(lnk.coproc_minor_reg_field, lnk.op2) != cp_ctrl_pkg::COP_NONE) begin
                  nxt_st.ack = 1'b0;
                  nxt_st.cache_req = 1'b1;
                  nxt_st.cache_op = dec_line_op(lnk.coproc_minor_reg_field, lnk.op2);
                  nxt_st.st = ST_WAIT_CACHE;
                end else if (lnk.op2 == cp_ctrl_pkg::OP2_WB &&
                             (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C10 || lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C0)) begin
                  nxt_st.ack = 1'b0;
                  nxt_st.wb_drain = 1'b1;
                  nxt_st.wfi = (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C0);
                  nxt_st.st = ST_WAIT_WB;
                end
              end else if (lnk.op2 == cp_ctrl_pkg::OP2_TEST &&
                           (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C10 || lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C14)) begin
                nxt_st.ack = 1'b0;
                nxt_st.cache_req = 1'b1;
                nxt_st.cache_op = cp_ctrl_pkg::COP_TEST_CLEAN;
                nxt_st.tci = (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C14);
                nxt_st.st = ST_WAIT_CACHE;
              end
            end
            cp_ctrl_pkg::CRN_TLB: begin
              // Undefined codes and reads complete with no effect.
              if (lnk.wr && lnk.op2 == cp_ctrl_pkg::OP2_0 &&
                  (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C5 || lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C6 ||
                   lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C7)) begin
                nxt_st.tlb_all = 1'b1;
              end
              if (lnk.wr && lnk.op2 == cp_ctrl_pkg::OP2_MVA &&
                  (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C5 || lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C6 ||
                   lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C7)) begin
                nxt_st.tlb_one = 1'b1;
                nxt_st.tlb_mva = lnk.wdata[31:cp_ctrl_pkg::TLB_MVA_LSB];
              end
            end
            cp_ctrl_pkg::CRN_LOCK: begin
              // Only minor field c0 reaches the lock registers; c1 and others answer zero.
              if (lnk.coproc_minor_reg_field == cp_ctrl_pkg::CRM_C0) begin
                if (lnk.op2 == cp_ctrl_pkg::OP2_0) begin
                  if (lnk.wr) nxt_st.dlock = lnk.wdata[cp_ctrl_pkg::LOCK_W-1:0];
                  nxt_st.rdata = {16'h0000, cp_ctrl_pkg::SBO_FIELD, st_ff.dlock};
                end else if (lnk.op2 == cp_ctrl_pkg::OP2_MVA) begin
                  if (lnk.wr) nxt_st.ilock = lnk.wdata[cp_ctrl_pkg::LOCK_W-1:0];
                  nxt_st.rdata = {16'h0000, cp_ctrl_pkg::SBO_FIELD, st_ff.ilock};
                end
              end
            end
            default: nxt_st.rdata = '0;
          endcase
        end
      end
      ST_WAIT_CACHE: begin
        if (cache_done) begin
          nxt_st.cache_req = 1'b0;
          nxt_st.rdata = '0;
          if (st_ff.cache_op == cp_ctrl_pkg::COP_TEST_CLEAN && st_ff.tci && !cache_dirty_left) begin
            nxt_st.st = ST_INV;
          end else begin
            nxt_st.ack = 1'b1;
            nxt_st.st = ST_IDLE;
            if (st_ff.cache_op == cp_ctrl_pkg::COP_TEST_CLEAN) begin
              nxt_st.rdata[cp_ctrl_pkg::CLEAN_BIT] = !cache_dirty_left;
              nxt_st.flags_load = st_ff.dest_pc;
            end
            if (st_ff.cache_op == cp_ctrl_pkg::COP_INV_ALL) begin
              nxt_st.rdata[cp_ctrl_pkg::CLEAN_BIT] = 1'b1;
              nxt_st.flags_load = st_ff.dest_pc;
            end
          end
        end
      end
      ST_INV: begin
        // One idle cycle on cache_req separates the clean step from the invalidate.
        nxt_st.cache_req = 1'b1;
        nxt_st.cache_op = cp_ctrl_pkg::COP_INV_ALL;
        nxt_st.st = ST_WAIT_CACHE;
      end
      ST_WAIT_WB: begin
        if (wb_empty) begin
          nxt_st.wb_drain = 1'b0;
          if (st_ff.wfi) begin
            nxt_st.low_power = 1'b1;
            nxt_st.st = ST_SLEEP;
          end else begin
            nxt_st.ack = 1'b1;
            nxt_st.st = ST_IDLE;
          end
        end
      end
      ST_SLEEP: begin
        if (st_ff.irq_s[1] || st_ff.dbg_s[1]) begin
          nxt_st.low_power = 1'b0;
          nxt_st.ack = 1'b1;
          nxt_st.st = ST_IDLE;
        end
      end
      default: nxt_st.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.ack        = st_ff.ack;
  assign lnk.rdata      = st_ff.rdata;
  assign lnk.flags_load = st_ff.flags_load;
  assign cache_req      = st_ff.cache_req;
  assign cache_op       = st_ff.cache_op;
  assign cache_set      = st_ff.cset;
  assign cache_way      = st_ff.cway;
  assign cache_mva      = st_ff.cmva;
  assign tlb_inv_all    = st_ff.tlb_all;
  assign tlb_inv_one    = st_ff.tlb_one;
  assign tlb_mva        = st_ff.tlb_mva;
  assign wb_drain       = st_ff.wb_drain;
  assign low_power      = st_ff.low_power;
  assign d_fill_way     = st_ff.dfill;
  assign i_fill_way     = st_ff.ifill;
endmodule : cache_tlb_maint_lockdown_ctrl

// file: src/core_cmd_port.sv
`timescale 1ns/1ns
module core_cmd_port (
  input  wire logic        pclk,     // Core clock.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB access phase.
  input  wire logic        pwrite,   // APB direction.
  input  wire logic [11:0] paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic [31:0]      prdata,   // APB read data.
  output logic             pready,   // APB ready.
  output logic             pslverr,  // APB error for unmapped address.
  cp_link_if.core          lnk       // Transfers to the coprocessor.
);
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  flags;
    logic        busy;
    logic        refused;
    logic        req;
    logic        wr;
    logic [3:0]  crn;
    logic [3:0]  coproc_minor_reg_field;
    logic [2:0]  op2;
    logic        dest_pc;
  } host_s;

  host_s st_ff;
  host_s nxt_st;

  // Clears the bits that must be zero for the chosen operation.
  function automatic logic [31:0] sbz_clear(input logic [3:0] crn, input logic [2:0] op2,
                                            input logic [31:0] d);
    sbz_clear = d;
    if (crn == cp_ctrl_pkg::CRN_CACHE && op2 == cp_ctrl_pkg::OP2_MVA)
      sbz_clear = {d[31:cp_ctrl_pkg::LINE_LSB], cp_ctrl_pkg::LINE_LSB'(0)};
    if (crn == cp_ctrl_pkg::CRN_CACHE && op2 == cp_ctrl_pkg::OP2_SETWAY)
      sbz_clear = {d[31 -: cp_ctrl_pkg::WAYS_LOG2],
                   (32 - cp_ctrl_pkg::WAYS_LOG2 - cp_ctrl_pkg::SETS_LOG2 - cp_ctrl_pkg::LINE_LSB)'(0),
                   d[cp_ctrl_pkg::LINE_LSB +: cp_ctrl_pkg::SETS_LOG2],
                   cp_ctrl_pkg::LINE_LSB'(0)};
    if (crn == cp_ctrl_pkg::CRN_CACHE && op2 == cp_ctrl_pkg::OP2_WB) sbz_clear = '0;
    if (crn == cp_ctrl_pkg::CRN_TLB && op2 == cp_ctrl_pkg::OP2_0) sbz_clear = '0;
    if (crn == cp_ctrl_pkg::CRN_TLB && op2 == cp_ctrl_pkg::OP2_MVA)
      sbz_clear = {d[31:cp_ctrl_pkg::TLB_MVA_LSB], cp_ctrl_pkg::TLB_MVA_LSB'(0)};
  endfunction : sbz_clear

  // Requests that software must never issue are held back here.
  function automatic logic illegal(input logic [31:0] cmd, input logic [31:0] d);
    logic [3:0] crn;
    logic [3:0] coproc_minor_reg_field;
    logic [2:0] op2;
    crn = cmd[cp_ctrl_pkg::CMD_CRN_LSB +: 4];
    coproc_minor_reg_field = cmd[cp_ctrl_pkg::CMD_CRM_LSB +: 4];
    op2 = cmd[cp_ctrl_pkg::CMD_OP2_LSB +: 3];
    illegal = 1'b0;
    if (crn == cp_ctrl_pkg::CRN_TLB && (!cmd[cp_ctrl_pkg::CMD_WR_BIT] || op2 > cp_ctrl_pkg::OP2_MVA ||
        !(coproc_minor_reg_field == cp_ctrl_pkg::CRM_C5 || coproc_minor_reg_field == cp_ctrl_pkg::CRM_C6 || coproc_minor_reg_field == cp_ctrl_pkg::CRM_C7)))
      illegal = 1'b1;
    if (crn == cp_ctrl_pkg::CRN_LOCK && coproc_minor_reg_field == cp_ctrl_pkg::CRM_C0 && cmd[cp_ctrl_pkg::CMD_WR_BIT] &&
        &d[cp_ctrl_pkg::LOCK_W-1:0])
      illegal = 1'b1;
  endfunction : illegal

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (st_ff.req && lnk.ack) begin
      nxt_st.req = 1'b0;
      nxt_st.busy = 1'b0;
      if (!st_ff.wr) nxt_st.rdata = lnk.rdata;
      if (lnk.flags_load) nxt_st.flags = lnk.rdata[31:cp_ctrl_pkg::FLAGS_LSB];
    end
    // First access cycle prepares the answer; the write lands at the pready edge.
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = '0;
      case (paddr)
        cp_ctrl_pkg::OFF_CMD: begin
          nxt_st.prdata[cp_ctrl_pkg::CMD_CRN_LSB +: 4] = st_ff.crn;
          nxt_st.prdata[cp_ctrl_pkg::CMD_CRM_LSB +: 4] = st_ff.coproc_minor_reg_field;
          nxt_st.prdata[cp_ctrl_pkg::CMD_OP2_LSB +: 3] = st_ff.op2;
          nxt_st.prdata[cp_ctrl_pkg::CMD_WR_BIT] = st_ff.wr;
          nxt_st.prdata[cp_ctrl_pkg::CMD_PC_BIT] = st_ff.dest_pc;
        end
        cp_ctrl_pkg::OFF_WDATA:  nxt_st.prdata = st_ff.wdata;
        cp_ctrl_pkg::OFF_RDATA:  nxt_st.prdata = st_ff.rdata;
        cp_ctrl_pkg::OFF_STATUS: begin
          nxt_st.prdata[cp_ctrl_pkg::STA_BUSY_BIT] = st_ff.busy;
          nxt_st.prdata[cp_ctrl_pkg::STA_REF_BIT] = st_ff.refused;
          nxt_st.prdata[cp_ctrl_pkg::STA_FLAGS_LSB +: 4] = st_ff.flags;
        end
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr) begin
      if (paddr == cp_ctrl_pkg::OFF_WDATA && !st_ff.busy) nxt_st.wdata = pwdata;
      if (paddr == cp_ctrl_pkg::OFF_CMD) begin
        if (st_ff.busy || illegal(pwdata, st_ff.wdata)) begin
          nxt_st.refused = 1'b1;
        end else begin
          nxt_st.refused = 1'b0;
          nxt_st.req = 1'b1;
          nxt_st.busy = 1'b1;
          nxt_st.crn = pwdata[cp_ctrl_pkg::CMD_CRN_LSB +: 4];
          nxt_st.coproc_minor_reg_field = pwdata[cp_ctrl_pkg::CMD_CRM_LSB +: 4];
          nxt_st.op2 = pwdata[cp_ctrl_pkg::CMD_OP2_LSB +: 3];
          nxt_st.wr = pwdata[cp_ctrl_pkg::CMD_WR_BIT];
          nxt_st.dest_pc = pwdata[cp_ctrl_pkg::CMD_PC_BIT];
          nxt_st.wdata = sbz_clear(pwdata[cp_ctrl_pkg::CMD_CRN_LSB +: 4],
                                   pwdata[cp_ctrl_pkg::CMD_OP2_LSB +: 3], st_ff.wdata);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata      = st_ff.prdata;
  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign lnk.req     = st_ff.req;
  assign lnk.wr      = st_ff.wr;
  assign lnk.crn     = st_ff.crn;
  assign lnk.coproc_minor_reg_field     = st_ff.coproc_minor_reg_field;
  assign lnk.op2     = st_ff.op2;
  assign lnk.dest_pc = st_ff.dest_pc;
  assign lnk.wdata   = st_ff.wdata;
endmodule : core_cmd_port

// file: test/ctrl_props.sv
`timescale 1ns/1ns
module ctrl_props (
  input wire logic        pclk,      // Clock.
  input wire logic        presetn,   // Reset.
  input wire logic        req,       // Request.
  input wire logic        wr,        // Write.
  input wire logic [3:0]  crn,       // Register.
  input wire logic [3:0]  coproc_minor_reg_field,       // Minor field.
  input wire logic [2:0]  op2,       // Opcode.
  input wire logic        dest_pc,   // To r15.
  input wire logic        ack,       // Done.
  input wire logic [31:0] rdata,     // Result.
  input wire logic        flags_load // Flags.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  lock_fmt_a: assert property (ack && !wr && crn == 4'h9 && coproc_minor_reg_field == 4'h0 |-> rdata[31:4] == 28'h0000FFF) else $error("lock fmt");
  rsv_zero_a: assert property (ack && !wr && crn == 4'h9 && coproc_minor_reg_field != 4'h0 |-> rdata == 32'h0) else $error("rsv");
  lock_imm_a: assert property ($rose(req) && crn == 4'h9 |=> ack) else $error("lock late");
  tlb_imm_a: assert property ($rose(req) && crn == 4'h8 |=> ack) else $error("tlb late");
  flags_src_a: assert property (flags_load |-> ack && !wr && dest_pc) else $error("flags");
  tclean_wait_a: assert property ($rose(req) && crn == 4'h7 && op2 == 3'h3 |=> !ack) else $error("tc");
  inv_sw_wait_a: assert property ($rose(req) && crn == 4'h7 && coproc_minor_reg_field == 4'h6 && op2 == 3'h2 |=> !ack) else $error("inv");
  wfi_wait_a: assert property ($rose(req) && crn == 4'h7 && coproc_minor_reg_field == 4'h0 |=> !ack [*2]) else $error("wfi");
endmodule : ctrl_props

// file: test/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top;
  logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic                   pready, pslverr, cache_req, cache_done = 1'b0, cache_dirty_left = 1'b0, low_power;
  logic                   tlb_inv_all, tlb_inv_one, wb_drain, wb_empty = 1'b1, irq_pin = 1'b0, saw_lp = 1'b0;
  logic                   dbg_pin = 1'b0, saw_wb = 1'b0, wk = 1'b0;
  logic [1:0]             d_repl_way = '0, i_repl_way = '0, d_fill_way, i_fill_way, cache_way, exp_d, exp_i;
  logic [3:0]             lk[2] = '{4'h0, 4'h0};
  logic [3:0]             v;
  logic [6:0]             cache_set;
  logic [8:0]             got_sw;
  logic [10:0]            ops[5] = '{11'h162, 11'h2A1, 11'h3A2, 11'h4E1, 11'h5E2};
  logic [11:0]            paddr = '0;
  logic [21:0]            tlb_mva;
  logic [31:0]            pwdata = '0, prdata, cache_mva, got_mva, rd, sta, seed = 32'h2BA3, rs = 32'h2BA3;
  cp_ctrl_pkg::cache_op_e cache_op, got_op;
  int                     n_fail = 0, tests_run = 0, dirt = 0, n_all = 0, n_one = 0, k;
  always #20 pclk = ~pclk;
  cp_link_if i_cp_link_if (.pclk, .presetn);
  core_cmd_port i_core_cmd_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lnk(i_cp_link_if));
  cache_tlb_maint_lockdown_ctrl i_cache_tlb_maint_lockdown_ctrl (.lnk(i_cp_link_if), .cache_req, .cache_op,
    .cache_set, .cache_way, .cache_mva, .cache_done, .cache_dirty_left, .tlb_inv_all, .tlb_inv_one, .tlb_mva,
    .wb_drain, .wb_empty, .low_power, .irq_pin, .dbg_pin, .d_repl_way, .i_repl_way, .d_fill_way, .i_fill_way);
  ctrl_props i_ctrl_props (.pclk, .presetn, .req(i_cp_link_if.req), .wr(i_cp_link_if.wr), .crn(i_cp_link_if.crn),
    .coproc_minor_reg_field(i_cp_link_if.coproc_minor_reg_field), .op2(i_cp_link_if.op2), .dest_pc(i_cp_link_if.dest_pc), .ack(i_cp_link_if.ack),
    .rdata(i_cp_link_if.rdata), .flags_load(i_cp_link_if.flags_load));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [1:0] fill(input logic [3:0] l, input logic [1:0] c);
    fill = 2'h3;
    for (int i = 3; i >= 0; i--) if (!l[c + 2'(i)]) fill = c + 2'(i);
  endfunction : fill
  // Cache side answers after a random delay; the dirty count drops by one per test-and-clean.
  always @(posedge pclk) begin
    rs = xs(rs);
    cache_done <= cache_req && !cache_done && rs[0];
    if (cache_req && !cache_done && rs[0]) begin
      got_op <= cache_op;
      {got_sw, got_mva} <= {cache_way, cache_set, cache_mva};
      cache_dirty_left <= dirt > (cache_op == cp_ctrl_pkg::COP_TEST_CLEAN);
      if (cache_op == cp_ctrl_pkg::COP_TEST_CLEAN && dirt > 0) dirt <= dirt - 1;
    end
    {wb_empty, d_repl_way, i_repl_way} <= {!wb_drain || rs[1], rs[5:2]};
    // The wake source is picked by the sequence so that both interrupt and debug wake get exercised.
    {irq_pin, dbg_pin} <= {low_power && !wk, low_power && wk};
    {exp_d, exp_i} <= {fill(lk[0], d_repl_way), fill(lk[1], i_repl_way)};
    saw_lp <= saw_lp | low_power;
    saw_wb <= saw_wb | wb_drain;
    n_all <= n_all + int'(tlb_inv_all);
    n_one <= n_one + int'(tlb_inv_one);
  end
  // The leading edge wait keeps a release and the next setup out of one time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (!pready && ++i < 20);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (i == 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : apb
  task automatic cmd(input logic [3:0] n, m, input logic [2:0] o, input logic w, p, input logic [31:0] d);
    int i = 0;
    apb(1'b1, 12'h004, d);
    apb(1'b1, 12'h000, {19'h0, p, w, o, m, n});
    do apb(1'b0, 12'h00C, 32'h0); while (rd[0] && ++i < 50);
    sta = rd;
    if (i == 50) begin
      n_fail++;
      tally_and_finish();
    end
    apb(1'b0, 12'h008, 32'h0);
  endtask : cmd
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cmd(4'h9, 4'h0, 3'h0, 1'b0, 1'b0, 32'h0); `CHK(rd, 32'h0000FFF0)
    for (int t = 0; t < 6; t++) begin
      seed = xs(seed);
      v = (t == 0) ? 4'hE : (seed[3:0] == 4'hF ? 4'h7 : seed[3:0]);
      cmd(4'h9, 4'h0, 3'(t % 2), 1'b1, 1'b0, {seed[31:4], v});
      lk[t % 2] = v;
      cmd(4'h9, 4'h0, 3'(t % 2), 1'b0, 1'b0, 32'h0); `CHK(rd, {28'h0000FFF, v})
      repeat (2) @(posedge pclk);
      repeat (4) begin @(posedge pclk); `CHK({d_fill_way, i_fill_way}, {exp_d, exp_i}) end
    end
    cmd(4'h9, 4'h0, 3'h0, 1'b1, 1'b0, 32'hF); `CHK(sta[1], 1'b1)
    cmd(4'h9, 4'h1, 3'h0, 1'b0, 1'b0, 32'h0); `CHK(rd, 32'h0)
    dirt = 3;
    k = 0;
    do begin
      cmd(4'h7, 4'hA, 3'h3, 1'b0, 1'b1, 32'h0);
      k++;
      `CHK({sta[7:4], rd}, {1'b0, k == 3, 2'h0, 1'b0, k == 3, 30'h0})
    end while (!rd[30] && k < 9);
    `CHK(k, 3)
    cmd(4'h7, 4'hE, 3'h3, 1'b0, 1'b1, 32'h0); `CHK({rd[30], got_op}, {1'b1, cp_ctrl_pkg::COP_INV_ALL})
    foreach (ops[q]) begin
      seed = xs(seed);
      cmd(4'h7, ops[q][7:4], ops[q][2:0], 1'b1, 1'b0, seed); `CHK(got_op, ops[q][10:8])
      if (ops[q][0]) `CHK(got_mva, {seed[31:5], 5'h0})
      else `CHK(got_sw, {seed[31:30], seed[11:5]})
    end
    for (int t = 0; t < 6; t++) begin
      seed = xs(seed);
      cmd(4'h8, 4'h5 + 4'(t / 2), 3'(t % 2), 1'b1, 1'b0, seed);
    end
    `CHK({n_all, n_one}, {32'd3, 32'd3})
    `CHK(tlb_mva, seed[31:10])
    cmd(4'h7, 4'hA, 3'h4, 1'b1, 1'b0, seed); `CHK({sta[0], saw_wb}, 2'b01)
    for (int t = 0; t < 2; t++) begin
      wk = t[0];
      cmd(4'h7, 4'h0, 3'h4, 1'b1, 1'b0, seed); `CHK(saw_lp, 1'b1)
    end
    cmd(4'h8, 4'h7, 3'h0, 1'b0, 1'b0, 32'h0); `CHK(sta[1], 1'b1)
    apb(1'b1, 12'h010, 32'h0); `CHK(err, 1'b1)
    tally_and_finish();
  end
endmodule : tb_top
